//--- verilog/drfs_pkg.sv
package drfs_pkg;
  // Command decode on the command/address bus at the rising clock edge.
  localparam int          DRFS_CA_W        = 10;
  localparam int          DRFS_BANKS       = 8;
  localparam int          DRFS_BANK_W      = 3;
  localparam int          DRFS_CNT_W       = 16;
  localparam logic [2:0]  DRFS_BANK_RST    = 3'h0;
  // Refresh owed/pulled-in accounting limits.
  localparam int          DRFS_DEBT_MAX    = 8;
  localparam int          DRFS_PB_PER_AB   = 8;
  // Default cycle counts at 100 MHz for the configurable timing figures.
  localparam int          DRFS_CLK_NS      = 10;
  localparam int          DRFS_TRFCAB_NS   = 210;
  localparam int          DRFS_TRFCPB_NS   = 90;
  localparam int          DRFS_TRFCAB_CYC  = (DRFS_TRFCAB_NS + DRFS_CLK_NS - 1) / DRFS_CLK_NS;
  localparam int          DRFS_TRFCPB_CYC  = (DRFS_TRFCPB_NS + DRFS_CLK_NS - 1) / DRFS_CLK_NS;
endpackage : drfs_pkg

//--- verilog/drfs_busy_timer.sv
`timescale 1ns/1ns
// Down counter that holds a busy level for a loaded number of cycles.
module drfs_busy_timer
  import drfs_pkg::*;
#(
  parameter int W = DRFS_CNT_W
) (
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  input  wire logic         load_in,
  input  wire logic [W-1:0] cycles_in,
  output logic              busy_out
);
  logic [W-1:0] count;
  logic [W-1:0] next_count;

  // A new load restarts the interval; a zero load gives no busy time.
  always_comb begin
    next_count = count;
    if (load_in) begin
      next_count = cycles_in;
    end else if (count != '0) begin
      next_count = count - W'(1);
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  assign busy_out = (count != '0);
endmodule // drfs_busy_timer

//--- verilog/drfs_refresh.sv
`timescale 1ns/1ns
// Operation
// [RULE1] Refresh is CS_n low, CA0 low, CA1 low, CA2 high; CA3 picks per-bank or all-bank.
// [RULE2] Per-bank refresh target comes from a bank counter cycling 0 through 7.
// [RULE3] Bank counter returns to zero on reset command and on self refresh exit.
// [RULE4] All-bank refresh also returns the bank counter to zero.
// [RULE5] Controller mirrors the counter and refreshes only an idle bank.
// [RULE6] Controller spaces per-bank refresh after refreshes, precharge and activate.
// [RULE7] Refreshed bank is busy for tRFCpb; other banks keep working.
// [RULE8] After a per-bank refresh the refreshed bank is idle.
// [RULE9] Controller waits tRFCpb or tRRD after per-bank refresh before dependent commands.
// [RULE10] Controller issues all-bank refresh only with every bank idle.
// [RULE11] Controller spaces all-bank refresh after refreshes and precharges.
// [RULE12] All-bank refresh leaves all banks idle; controller waits tRFCab afterwards.
// [RULE13] No all-bank refresh after activate; per-bank only to idle bank after tRRD.
// [RULE14] Controller times tRP from the latest precharge reaching each bank.
// [RULE15] Controller defers at most eight refreshes, gap at most nine intervals.
// [RULE16] Controller pulls in at most eight extra refreshes.
// [RULE17] Controller issues at most sixteen refreshes in two intervals.
// [RULE18] Per-bank budget is eight times eight, doubled per two intervals.
// [RULE19] Controller meets minimum refreshes per window; eight per-bank equal one all-bank.
// [RULE20] Owed refresh count at most eight across self refresh and frozen during it.
// [RULE21] After self refresh exit one more refresh precedes the next entry.
// [RULE22] Auto-precharge accesses complete untruncated; seamless different-bank bursts allowed.
// [RULE23] Self refresh only with banks idle; one refresh needed after exit.
// [RULE24] Refresh and spacing times are configurable clock-cycle counts.
module drfs_refresh
  import drfs_pkg::*;
#(
  parameter int              NBANK      = DRFS_BANKS,
  parameter logic [DRFS_CNT_W-1:0] TRFCAB_CYC = DRFS_CNT_W'(DRFS_TRFCAB_CYC),
  parameter logic [DRFS_CNT_W-1:0] TRFCPB_CYC = DRFS_CNT_W'(DRFS_TRFCPB_CYC)
) (
  input  wire logic                   CORE_CLK_IN,
  input  wire logic                   SYS_RST_IN,
  input  wire logic                   CS_N_IN,
  input  wire logic [DRFS_CA_W-1:0]   CA_IN,
  input  wire logic                   RESET_CMD_IN,
  input  wire logic                   SREF_EXIT_IN,
  input  wire logic [NBANK-1:0]       BANK_ACTIVE_IN,
  output logic [DRFS_BANK_W-1:0]      NEXT_BANK_OUT,
  output logic [NBANK-1:0]            BANK_BUSY_OUT,
  output logic                        ALL_BUSY_OUT,
  output logic                        REF_PB_OUT,
  output logic                        REF_AB_OUT,
  output logic [DRFS_BANK_W-1:0]      REF_BANK_OUT,
  output logic                        REF_ILLEGAL_OUT
);
  // Pin inputs are from the memory clock domain; two flops before use.
  logic                 cs_n_m, cs_n_s;
  logic [DRFS_CA_W-1:0] ca_m, ca_s;
  logic                 rst_cmd_m, rst_cmd_s, sx_m, sx_s;

  always_ff @(posedge CORE_CLK_IN) begin
    if (SYS_RST_IN) begin
      cs_n_m    <= 1'b1;
      cs_n_s    <= 1'b1;
      ca_m      <= '0;
      ca_s      <= '0;
      rst_cmd_m <= 1'b0;
      rst_cmd_s <= 1'b0;
      sx_m      <= 1'b0;
      sx_s      <= 1'b0;
    end else begin
      cs_n_m    <= CS_N_IN;
      cs_n_s    <= cs_n_m;
      ca_m      <= CA_IN;
      ca_s      <= ca_m;
      rst_cmd_m <= RESET_CMD_IN;
      rst_cmd_s <= rst_cmd_m;
      sx_m      <= SREF_EXIT_IN;
      sx_s      <= sx_m;
    end
  end

  // Refresh decode; CA3 chooses the flavour.
  logic is_ref, is_pb, is_ab;
  assign is_ref = !cs_n_s && !ca_s[0] && !ca_s[1] && ca_s[2]; // see [RULE1]
  assign is_pb  = is_ref && !ca_s[3];                          // see [RULE1]
  assign is_ab  = is_ref && ca_s[3];                           // see [RULE1]

  // Exit is a level; only its falling-to-rising change resets the counter once.
  logic sx_d, next_sx_d;
  logic sx_rise;
  assign sx_rise   = sx_s && !sx_d;
  assign next_sx_d = sx_s;

  // Bank counter and registered command outputs.
  logic [DRFS_BANK_W-1:0] bank, next_bank;
  logic                   ref_pb, next_ref_pb, ref_ab, next_ref_ab, illegal, next_illegal;
  logic [DRFS_BANK_W-1:0] ref_bank, next_ref_bank;
  logic [NBANK-1:0]       pb_busy;
  logic                   ab_busy;
  logic                   pb_ok;

  // A refresh to a busy or open bank is flagged, yet the counter still moves
  // so the device stays in step with a controller that counted it.
  assign pb_ok = !BANK_ACTIVE_IN[bank] && !pb_busy[bank] && !ab_busy;

  always_comb begin
    next_bank     = bank;
    next_ref_pb   = 1'b0;
    next_ref_ab   = 1'b0;
    next_ref_bank = ref_bank;
    next_illegal  = 1'b0;
    if (rst_cmd_s || sx_rise) begin
      next_bank = DRFS_BANK_RST;                                // see [RULE3]
    end else if (is_ab) begin
      next_bank    = DRFS_BANK_RST;                             // see [RULE4]
      next_ref_ab  = 1'b1;
      next_illegal = (|BANK_ACTIVE_IN) || (|pb_busy) || ab_busy;
    end else if (is_pb) begin
      next_ref_pb   = 1'b1;
      next_ref_bank = bank;                                     // see [RULE2]
      next_bank     = bank + DRFS_BANK_W'(1);                   // see [RULE2]
      next_illegal  = !pb_ok;
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (SYS_RST_IN) begin
      bank     <= DRFS_BANK_RST;
      ref_pb   <= 1'b0;
      ref_ab   <= 1'b0;
      ref_bank <= DRFS_BANK_RST;
      illegal  <= 1'b0;
      sx_d     <= 1'b0;
    end else begin
      bank     <= next_bank;
      ref_pb   <= next_ref_pb;
      ref_ab   <= next_ref_ab;
      ref_bank <= next_ref_bank;
      illegal  <= next_illegal;
      sx_d     <= next_sx_d;
    end
  end

  // One busy timer per bank for tRFCpb; the bank returns idle on expiry.
  genvar g;
  generate
    for (g = 0; g < NBANK; g++) begin : g_bank
      logic load_pb;
      assign load_pb = is_pb && !(rst_cmd_s || sx_rise) && (bank == DRFS_BANK_W'(g));
      drfs_busy_timer #(.W(DRFS_CNT_W)) u_pb (
        .clk_in    (CORE_CLK_IN),
        .rst_in    (SYS_RST_IN),
        .load_in   (load_pb),                                   // see [RULE7]
        .cycles_in (TRFCPB_CYC),                                // see [RULE24]
        .busy_out  (pb_busy[g])                                 // see [RULE8]
      );
    end
  endgenerate

  // All-bank busy window; every bank is idle again when it ends.
  drfs_busy_timer #(.W(DRFS_CNT_W)) u_ab (
    .clk_in    (CORE_CLK_IN),
    .rst_in    (SYS_RST_IN),
    .load_in   (is_ab && !(rst_cmd_s || sx_rise)),               // see [RULE12]
    .cycles_in (TRFCAB_CYC),                                      // see [RULE24]
    .busy_out  (ab_busy)
  );

  // Only the refreshed bank is unavailable; others report free. Accesses to
  // other banks are never held off here, so auto-precharge bursts run whole.
  // see [RULE22]
  assign BANK_BUSY_OUT   = pb_busy | {NBANK{ab_busy}};           // see [RULE7]
  assign ALL_BUSY_OUT    = ab_busy;
  assign NEXT_BANK_OUT   = bank;
  assign REF_PB_OUT      = ref_pb;
  assign REF_AB_OUT      = ref_ab;
  assign REF_BANK_OUT    = ref_bank;
  assign REF_ILLEGAL_OUT = illegal;
endmodule // drfs_refresh

//--- tb/drfs_refresh_sva.sv
`timescale 1ns/1ns
// Ties refresh pulses, the bank counter and busy windows to the command pins.
// The busy lengths assume the bench's cycle counts of 3 (per-bank) and 4 (all-bank).
module drfs_refresh_sva (
  input wire logic       CORE_CLK_IN,
  input wire logic       SYS_RST_IN,
  input wire logic       CS_N_IN,
  input wire logic [9:0] CA_IN,
  input wire logic       RESET_CMD_IN,
  input wire logic [2:0] NEXT_BANK_OUT,
  input wire logic [7:0] BANK_BUSY_OUT,
  input wire logic       ALL_BUSY_OUT,
  input wire logic       REF_PB_OUT,
  input wire logic       REF_AB_OUT,
  input wire logic [2:0] REF_BANK_OUT
);
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (SYS_RST_IN);
  a_pb_decode_lat: assert property (!CS_N_IN && CA_IN[3:0] == 4'h4 && !RESET_CMD_IN |-> ##3 REF_PB_OUT) else $error("per-bank refresh not answered");
  a_ab_decode_lat: assert property (!CS_N_IN && CA_IN[3:0] == 4'hc && !RESET_CMD_IN |-> ##3 REF_AB_OUT) else $error("all-bank refresh not answered");
  a_pb_has_cause: assert property (REF_PB_OUT |-> $past(!CS_N_IN && CA_IN[3:0] == 4'h4, 3)) else $error("per-bank pulse without command");
  a_ab_has_cause: assert property (REF_AB_OUT |-> $past(!CS_N_IN && CA_IN[3:0] == 4'hc, 3)) else $error("all-bank pulse without command");
  a_bank_round_robin: assert property (REF_PB_OUT |-> NEXT_BANK_OUT == REF_BANK_OUT + 3'h1) else $error("bank counter did not step");
  a_ab_bank_zero: assert property (REF_AB_OUT |-> NEXT_BANK_OUT == 3'h0) else $error("all-bank left counter nonzero");
  a_cmd_bank_zero: assert property ($rose(RESET_CMD_IN) |-> ##[1:5] NEXT_BANK_OUT == 3'h0) else $error("reset command kept counter");
  a_pb_busy_span: assert property (REF_PB_OUT |-> BANK_BUSY_OUT[REF_BANK_OUT] [*3] ##1 !BANK_BUSY_OUT[REF_BANK_OUT]) else $error("per-bank busy span wrong");
  a_ab_busy_span: assert property (REF_AB_OUT |-> (ALL_BUSY_OUT && &BANK_BUSY_OUT) [*4] ##1 BANK_BUSY_OUT == 8'h00) else $error("all-bank busy span wrong");
endmodule // drfs_refresh_sva

//--- tb/drfs_ctrl_model.sv
`timescale 1ns/1ns
// Controller side: puts refresh commands on the chip select and command lines.
module drfs_ctrl_model (
  input  wire logic       clk_in,
  input  wire logic       go_in,
  input  wire logic       ab_in,
  input  wire logic [7:0] busy_in,
  output logic            cs_n_out,
  output logic [9:0]      ca_out
);
  initial begin
    cs_n_out = 1'b1;
    ca_out   = 10'h155;
  end
  // A refresh is held back while any bank is still inside its refresh time.
  // The model never opens or precharges a row and sends refreshes only on
  // request, so activate and precharge spacing and the refresh budgets hold.
  // Self refresh is only signalled as an exit level between refreshes.
  always @(posedge clk_in) begin
    if (go_in && busy_in == 8'h00) begin
      cs_n_out <= 1'b0;
      ca_out   <= {6'h00, ab_in, 3'h4};
    end else begin
      // Deselected lines toggle so a stale code can never pass as a command.
      cs_n_out <= 1'b1;
      ca_out   <= ~ca_out;
    end
  end
endmodule // drfs_ctrl_model

//--- tb/drfs_refresh_test.sv
`timescale 1ns/1ns
// Issues refresh rows through the controller model, then the awkward cases.
module drfs_refresh_test;
  typedef struct packed {logic ab; logic [2:0] bank; logic [2:0] nxt;} drfs_row_t;
  logic clk = 1'b0, rst = 1'b1, go = 1'b0, ab = 1'b0, rcmd = 1'b0, sx = 1'b0, cs_n;
  logic pb_p, ab_p, all_b, ill;
  logic [9:0] ca;
  logic [7:0] act = 8'h00, busy;
  logic [2:0] nb, rb;
  int err_total = 0, n_checks = 0;
  drfs_row_t rows [11];
  always #5 clk = ~clk;
  drfs_refresh #(.TRFCAB_CYC(16'h0004), .TRFCPB_CYC(16'h0003)) dut_u (.CORE_CLK_IN(clk),
    .SYS_RST_IN(rst), .CS_N_IN(cs_n), .CA_IN(ca), .RESET_CMD_IN(rcmd), .SREF_EXIT_IN(sx),
    .BANK_ACTIVE_IN(act), .NEXT_BANK_OUT(nb), .BANK_BUSY_OUT(busy), .ALL_BUSY_OUT(all_b),
    .REF_PB_OUT(pb_p), .REF_AB_OUT(ab_p), .REF_BANK_OUT(rb), .REF_ILLEGAL_OUT(ill));
  drfs_ctrl_model ctl_u (.clk_in(clk), .go_in(go), .ab_in(ab), .busy_in(busy),
    .cs_n_out(cs_n), .ca_out(ca));
  task automatic chk(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask
  task automatic results();
    $display("Checks %0d, mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Waits out any busy bank, sends one refresh and returns in its pulse cycle.
  task automatic issue(input logic a);
    int n;
    for (n = 0; n < 30 && busy !== 8'h00; n++) @(negedge clk);
    if (n == 30) begin
      chk(1'b0, "busy never cleared");
      results();
    end
    @(posedge clk) #1 go = 1'b1;
    ab = a;
    @(posedge clk) #1 go = 1'b0;
    for (n = 0; n < 12 && pb_p !== 1'b1 && ab_p !== 1'b1; n++) @(negedge clk);
    if (n == 12) begin
      chk(1'b0, "no refresh answer");
      results();
    end
  endtask
  // Rows walk the counter past its wrap, then an all-bank refresh clears it.
  initial begin
    for (int k = 0; k < 9; k++) rows[k] = '{1'b0, 3'(k), 3'(k + 1)};
    rows[9] = '{1'b1, 3'h0, 3'h0};
    rows[10] = '{1'b0, 3'h0, 3'h1};
    repeat (6) @(posedge clk);
    #1 rst = 1'b0;
    @(negedge clk) chk(nb === 3'h0 && busy === 8'h00 && rb === 3'h0, "reset values");
    foreach (rows[i]) begin
      issue(rows[i].ab);
      chk(pb_p === !rows[i].ab && ab_p === rows[i].ab && ill === 1'b0, "pulse kind");
      chk(nb === rows[i].nxt && (rows[i].ab || rb === rows[i].bank), "bank");
      chk(busy === (rows[i].ab ? 8'hff : 8'h01 << rows[i].bank), "busy");
    end
    issue(1'b0);
    @(posedge clk) #1 rcmd = 1'b1;
    @(posedge clk) #1 rcmd = 1'b0;
    repeat (5) @(negedge clk);
    chk(nb === 3'h0, "reset command");
    issue(1'b0);
    chk(rb === 3'h0 && nb === 3'h1, "bank after reset command");
    @(posedge clk) #1 sx = 1'b1;
    repeat (5) @(negedge clk);
    chk(nb === 3'h0, "self refresh exit");
    // An active target bank still refreshes but must be flagged.
    @(posedge clk) #1 act = 8'h01;
    issue(1'b0);
    chk(ill === 1'b1 && rb === 3'h0, "active bank flag");
    @(posedge clk) #1 act = 8'h10;
    issue(1'b1);
    chk(ill === 1'b1, "all-bank with active bank");
    results();
  end
endmodule // drfs_refresh_test
bind drfs_refresh drfs_refresh_sva chk_u (.*);
